// *** chb_access.sv ***
`timescale 1ns/100ps
`include "chb_defs.svh"
module chb_access import chb_pkg::*; #(
   parameter int LOW_HOLD_CYC = `CHB_LOW_HOLD_CYC,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic low_lane_enable_n,
   input wire logic high_lane_enable_n,
   input wire logic attr_select_n,
   input wire logic [2:0] addr,
   input wire logic port_read_strobe_n,
   input wire logic port_write_strobe_n,
   input wire logic mem_read_strobe_n,
   input wire logic mem_write_strobe_n,
   input wire logic interface_select_input_n,
   input wire logic task_file_select_n,
   input wire logic control_block_select_n,
   input wire logic dma_grant_n,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic data_hi_oe,
   output logic data_lo_oe,
   output logic wide_port_indicator_n,
   output logic wait_n,
   output logic disk_mode,
   output logic [1:0] speed_sel,
   output logic [7:0] speed_byte,
   output logic [7:0] speed_ext_byte,
   output logic speed_has_ext,
   input wire logic [15:0] rd_word,
   output logic rd_taken,
   output logic [2:0] reg_index,
   output logic reg_is_ctrl,
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [15:0] wr_data,
   output logic [1:0] wr_lanes,
   output logic [2:0] wr_index,
   output logic wr_is_ctrl,
   input wire logic [1:0] speed_cfg
);
   // ************************************************
   // Pin synchronisers
   // ************************************************
   logic ce1_s, ce2_s, reg_s, ior_s, iow_s, oe_s, we_s, sel_s, cs0_s, cs1_s;
   logic dmk_s;
   logic [10:0] raw_in, syn_out;
   assign raw_in = {low_lane_enable_n, high_lane_enable_n, attr_select_n,
      port_read_strobe_n, port_write_strobe_n, mem_read_strobe_n,
      mem_write_strobe_n, interface_select_input_n, task_file_select_n,
      control_block_select_n, dma_grant_n};
   for (genvar g = 0; g < 11; g++) begin : g_sync
      chb_sync u_sync (
         .clk(clk),
         .reset(reset),
         .din(raw_in[g]),
         .dout(syn_out[g])
      );
   end
   assign {ce1_s, ce2_s, reg_s, ior_s, iow_s, oe_s, we_s, sel_s, cs0_s,
      cs1_s, dmk_s} = syn_out;
   // Address and data settle long before strobes, so they are sampled raw
   // ************************************************
   // State
   // ************************************************
   typedef struct packed {
      chb_phase_t ph;
      logic [3:0] wcnt;
      logic disk;
      logic decided;
      logic [2:0] settle;
      logic [31:0] lowcnt;
      logic [15:0] dout;
      logic hi_oe;
      logic lo_oe;
      logic wr_prev;
   } chb_st_t;
   chb_st_t s_q, s_d;
   logic fifo_in_ready, fifo_out_valid;
   logic [23:0] fifo_out;
   logic rd_act, wr_act, sock_sel, ide_sel, dma_sel, wr_edge;
   logic hi_lane, lo_lane, word_acc;
   function automatic logic [7:0] pick_byte(input logic [15:0] w,
                                            input logic odd);
      pick_byte = odd ? w[15:8] : w[7:0];
   endfunction
   // ************************************************
   // Access decode
   // ************************************************
   always_comb begin
      sock_sel = !s_q.disk && (!ce1_s || !ce2_s);
      ide_sel = s_q.disk && (cs0_s != cs1_s) && dmk_s;
      dma_sel = s_q.disk && cs0_s && cs1_s && !dmk_s;
      word_acc = s_q.disk ? (dma_sel || (ide_sel && !cs0_s &&
         addr == `CHB_ADDR_DATA)) : (!ce1_s && !ce2_s);
      hi_lane = s_q.disk ? word_acc : !ce2_s;
      lo_lane = s_q.disk ? (ide_sel || dma_sel) : !ce1_s;
      if (s_q.disk) begin
         rd_act = (ide_sel || dma_sel) && !ior_s;
         wr_act = (ide_sel || dma_sel) && !iow_s;
      end else if (!reg_s) begin
         rd_act = sock_sel && !ior_s;
         wr_act = sock_sel && !iow_s;
      end else begin
         rd_act = sock_sel && !oe_s;
         wr_act = sock_sel && !we_s;
      end
   end
   assign wr_edge = wr_act && !s_q.wr_prev;
   // ************************************************
   // Next state
   // ************************************************
   always_comb begin
      s_d = s_q;
      s_d.wr_prev = wr_act;
      // Interface mode arbitration
      // Synchronisers reset high, so decide only once they show the pin
      if (!s_q.decided) begin
         if (s_q.settle == 3'h4) begin
            s_d.decided = 1'b1;
            s_d.disk = !sel_s;
         end else begin
            s_d.settle = s_q.settle + 3'h1;
         end
      end else if (sel_s) begin
         s_d.disk = 1'b0;
         s_d.lowcnt = '0;
      end else if (!s_q.disk) begin
         s_d.lowcnt = s_q.lowcnt + 32'h1;
         if (s_q.lowcnt >= 32'(LOW_HOLD_CYC - 1)) begin
            s_d.disk = 1'b1;
         end
      end
      // Read cycle with wait stretch
      unique case (s_q.ph)
         CHB_IDLE: begin
            s_d.hi_oe = 1'b0;
            s_d.lo_oe = 1'b0;
            if (rd_act) begin
               s_d.ph = CHB_WAIT;
               s_d.wcnt = `CHB_WAIT_CYC;
            end
         end
         CHB_WAIT: begin
            if (!rd_act) begin
               s_d.ph = CHB_IDLE;
            end else if (s_q.wcnt == 4'h1) begin
               s_d.ph = CHB_BUSY;
               s_d.hi_oe = hi_lane;
               s_d.lo_oe = lo_lane;
               if (word_acc) begin
                  s_d.dout = rd_word;
               end else if (hi_lane && !lo_lane) begin
                  s_d.dout = {rd_word[15:8], 8'h00};
               end else begin
                  s_d.dout = {8'h00, s_q.disk ? rd_word[7:0]
                     : pick_byte(rd_word, addr[0])};
               end
            end else begin
               s_d.wcnt = s_q.wcnt - 4'h1;
            end
         end
         CHB_BUSY: begin
            if (!rd_act) begin
               s_d.ph = CHB_IDLE;
               s_d.hi_oe = 1'b0;
               s_d.lo_oe = 1'b0;
            end
         end
         default: s_d.ph = CHB_IDLE;
      endcase
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q <= '{ph: CHB_IDLE, wcnt: 4'h0, disk: 1'b0, decided: 1'b0,
            settle: 3'h0,
            lowcnt: 32'h0, dout: 16'h0000, hi_oe: 1'b0, lo_oe: 1'b0,
            wr_prev: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end
   // ************************************************
   // Write path through the FIFO
   // ************************************************
   // Writes arriving while the FIFO is full are dropped; depth covers bursts
   logic [23:0] fifo_in;
   logic [1:0] lanes;
   logic [15:0] wword;
   always_comb begin
      lanes = {hi_lane, lo_lane};
      wword = data_in;
      if (!word_acc && lo_lane && !s_q.disk && addr[0]) begin
         wword = {data_in[7:0], 8'h00};
         lanes = 2'h2;
      end else if (!word_acc && lo_lane) begin
         wword = {8'h00, data_in[7:0]};
         lanes = 2'h1;
      end else if (!word_acc && hi_lane) begin
         wword = {data_in[15:8], 8'h00};
         lanes = 2'h2;
      end
      fifo_in = {2'h0, !cs1_s && s_q.disk, addr, lanes, wword};
   end
   chb_fifo #(
      .WIDTH(24),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .reset(reset),
      .in_valid(wr_edge),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(wr_ready),
      .out_data(fifo_out)
   );
   assign wr_valid = fifo_out_valid;
   assign wr_data = fifo_out[15:0];
   assign wr_lanes = fifo_out[17:16];
   assign wr_index = fifo_out[20:18];
   assign wr_is_ctrl = fifo_out[21];
   // ************************************************
   // Outputs
   // ************************************************
   assign data_out = s_q.dout;
   assign data_hi_oe = s_q.hi_oe;
   assign data_lo_oe = s_q.lo_oe;
   assign wide_port_indicator_n = !(sock_sel && !reg_s);
   assign wait_n = !(s_q.ph == CHB_WAIT || (wr_act && !fifo_in_ready));
   assign disk_mode = s_q.disk;
   assign rd_taken = (s_q.ph == CHB_WAIT) && (s_q.wcnt == 4'h1) && rd_act;
   assign reg_index = addr;
   assign reg_is_ctrl = s_q.disk && !cs1_s;
   always_comb begin
      speed_has_ext = 1'b0;
      speed_ext_byte = 8'h00;
      unique case (speed_cfg)
         2'h0: speed_byte = `CHB_SPEED_250;
         2'h2: speed_byte = `CHB_SPEED_100;
         2'h1: begin
            speed_byte = `CHB_SPEED_EXT;
            speed_ext_byte = `CHB_EXT_120;
            speed_has_ext = 1'b1;
         end
         default: begin
            speed_byte = `CHB_SPEED_EXT;
            speed_ext_byte = `CHB_EXT_80;
            speed_has_ext = 1'b1;
         end
      endcase
   end
   assign speed_sel = speed_cfg;
   // ************************************************
   // Checks
   // ************************************************
   a_wide_ind: assert property (@(posedge clk) disable iff (reset)
      (sock_sel && !reg_s) |-> !wide_port_indicator_n)
      else $error("wide indicator not asserted");
   a_wp_bit: assert property (@(posedge clk) disable iff (reset)
      speed_byte[`CHB_WP_BIT] == 1'b1)
      else $error("speed byte bit 3 not set");
   a_ext_bit: assert property (@(posedge clk) disable iff (reset)
      speed_ext_byte[`CHB_EXT_MORE_BIT] == 1'b0)
      else $error("extension bit 7 set");
   a_sel_high: assert property (@(posedge clk) disable iff (reset)
      (s_q.decided && sel_s) |=> !disk_mode)
      else $error("disk mode while select high");
   a_wait_rd: assert property (@(posedge clk) disable iff (reset)
      (s_q.ph == CHB_IDLE && rd_act) |=> !wait_n)
      else $error("wait missing at read start");
   a_drive_lo: assert property (@(posedge clk) disable iff (reset)
      (rd_taken && !word_acc && lo_lane && !s_q.disk) |=> data_lo_oe
      && !data_hi_oe) else $error("byte read lanes wrong");
   a_word_rd: assert property (@(posedge clk) disable iff (reset)
      (rd_taken && word_acc) |=> (data_out == $past(rd_word)))
      else $error("word read data wrong");
   a_hi_only: assert property (@(posedge clk) disable iff (reset)
      (rd_taken && hi_lane && !lo_lane) |=> !data_lo_oe && data_hi_oe)
      else $error("high only lanes wrong");
endmodule

// *** chb_defs.svh ***
`ifndef CHB_DEFS_SVH
`define CHB_DEFS_SVH
`define CHB_SPEED_250 8'hD9
`define CHB_SPEED_100 8'hDC
`define CHB_SPEED_EXT 8'hDF
`define CHB_EXT_120 8'h12
`define CHB_EXT_80 8'h79
`define CHB_WP_BIT 3
`define CHB_EXT_MORE_BIT 7
`define CHB_ADDR_DATA 3'h0
`define CHB_ADDR_CTRL 3'h6
`define CHB_WAIT_CYC 4'h2
`define CHB_LOW_HOLD_MS 100
`define CHB_CLK_KHZ 25000
`define CHB_LOW_HOLD_CYC (`CHB_LOW_HOLD_MS * `CHB_CLK_KHZ)
`endif

// *** chb_fifo.sv ***
`timescale 1ns/100ps
module chb_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } chb_fifo_st_t;
   chb_fifo_st_t s_q, s_d;
   logic push, pop;
   assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_q.cnt != '0);
   assign out_data = s_q.mem[s_q.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wp] = in_data;
         s_d.wp = s_q.wp + 1'b1;
      end
      if (pop) begin
         s_d.rp = s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// *** chb_host.sv ***
`timescale 1ns/100ps
module chb_host (
   input wire logic clk,
   output logic low_lane_enable_n,
   output logic high_lane_enable_n,
   output logic attr_select_n,
   output logic [2:0] addr,
   output logic port_read_strobe_n,
   output logic port_write_strobe_n,
   output logic mem_read_strobe_n,
   output logic mem_write_strobe_n,
   output logic task_file_select_n,
   output logic control_block_select_n,
   output logic dma_grant_n,
   output logic [15:0] data_in,
   input wire logic wait_n,
   input wire logic data_hi_oe,
   input wire logic data_lo_oe,
   input wire logic wide_port_indicator_n,
   input wire logic [15:0] data_out
);
   logic saw_wait;
   logic wide_seen;
   initial begin
      {low_lane_enable_n, high_lane_enable_n, attr_select_n} = 3'h7;
      {port_read_strobe_n, port_write_strobe_n} = 2'h3;
      {mem_read_strobe_n, mem_write_strobe_n} = 2'h3;
      {task_file_select_n, control_block_select_n, dma_grant_n} = 3'h7;
      addr = 3'h0;
      data_in = 16'h0000;
      saw_wait = 1'b0;
      wide_seen = 1'b0;
   end
   // ******************************
   // Host cycle
   // ******************************
   // Space 0 port, 1 common memory, 2 disk task file
   task automatic xfer(input logic [1:0] sp, input logic wr,
      input logic [1:0] ce_n, input logic [2:0] a, input logic [15:0] wd,
      input int lim, output logic [15:0] rd, output logic [1:0] oe);
      int n;
      @(negedge clk);
      {high_lane_enable_n, low_lane_enable_n} = ce_n;
      attr_select_n = (sp == 2'h1);
      task_file_select_n = (sp != 2'h2); // Only one select at a time
      addr = a;
      data_in = wd;
      saw_wait = 1'b0;
      if (sp == 2'h1) begin
         {mem_write_strobe_n, mem_read_strobe_n} = {!wr, wr};
      end else begin
         {port_write_strobe_n, port_read_strobe_n} = {!wr, wr};
      end
      n = 0;
      // Cycle stretched while wait is low, bounded
      while (n < lim && (n < 6 || !wait_n ||
             (!wr && !(data_hi_oe || data_lo_oe)))) begin
         @(negedge clk);
         if (!wait_n) begin
            saw_wait = 1'b1;
         end
         n++;
      end
      rd = data_out;
      oe = {data_hi_oe, data_lo_oe};
      wide_seen = !wide_port_indicator_n;
      {port_read_strobe_n, port_write_strobe_n} = 2'h3;
      {mem_read_strobe_n, mem_write_strobe_n} = 2'h3;
      {low_lane_enable_n, high_lane_enable_n} = 2'h3;
      task_file_select_n = 1'b1;
      // Released bus shows the inverse so stale data cannot pass
      data_in = ~wd;
      repeat (5) @(negedge clk);
   endtask
endmodule

// *** chb_pkg.sv ***
package chb_pkg;
   typedef enum logic [1:0] {CHB_IDLE, CHB_WAIT, CHB_BUSY} chb_phase_t;
   typedef enum logic [1:0] {
      CHB_SPD_250, CHB_SPD_120, CHB_SPD_100, CHB_SPD_80
   } chb_speed_t;
endpackage

// *** chb_sync.sv ***
`timescale 1ns/100ps
module chb_sync (
   input wire logic clk,
   input wire logic reset,
   input wire logic din,
   output logic dout
);
   // ************************************************
   // Three stages; change taken when stages 2 and 3 agree
   // ************************************************
   typedef struct packed {
      logic [2:0] sh;
      logic o;
   } chb_sync_st_t;
   chb_sync_st_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.sh = {s_q.sh[1:0], din};
      if (s_q.sh[2] == s_q.sh[1]) begin
         s_d.o = s_q.sh[2];
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q <= '{sh: 3'h7, o: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end
   assign dout = s_q.o;
endmodule

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
   localparam logic [15:0] RDW = 16'hC35A;
   logic clk = 1'b0;
   logic reset, low_lane_enable_n, high_lane_enable_n, attr_select_n;
   logic [2:0] addr, reg_index, wr_index;
   logic port_read_strobe_n, port_write_strobe_n, mem_read_strobe_n;
   logic mem_write_strobe_n, interface_select_input_n, task_file_select_n;
   logic control_block_select_n, dma_grant_n, data_hi_oe, data_lo_oe;
   logic [15:0] data_in, data_out, rd_word, wr_data, rd;
   logic wide_port_indicator_n, wait_n, disk_mode, speed_has_ext, rd_taken;
   logic [1:0] speed_sel, wr_lanes, speed_cfg, oe;
   logic [7:0] speed_byte, speed_ext_byte;
   logic reg_is_ctrl, wr_valid, wr_ready, wr_is_ctrl;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   always #20 clk = ~clk;
   chb_access #(.LOW_HOLD_CYC(50), .FIFO_DEPTH(16)) u_chb_access (.*);
   chb_host u_chb_host (.*);
   // ******************************
   // Reporting
   // ******************************
   task automatic finish_test();
      if (err_total == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Ceiling well above the roughly 550 cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         finish_test();
      end
   end
   // ******************************
   // Scenarios
   // ******************************
   task automatic t_speed();
      logic [7:0] b[4] = '{8'hD9, 8'hDF, 8'hDC, 8'hDF};
      logic [7:0] x[4] = '{8'h00, 8'h12, 8'h00, 8'h79};
      for (int i = 0; i < 4; i++) begin
         speed_cfg = i[1:0];
         @(negedge clk);
         chk("speed code", {8'h00, b[i]}, {8'h00, speed_byte});
         chk("speed sel", {14'h0, i[1:0]}, {14'h0, speed_sel});
         chk("ext flag", {15'h0, x[i] != 8'h00}, {15'h0, speed_has_ext});
         if (x[i] != 8'h00) begin
            chk("speed ext", {8'h00, x[i]}, {8'h00, speed_ext_byte});
         end
      end
   endtask
   task automatic t_read();
      logic [1:0] ce;
      logic [15:0] m;
      logic [15:0] e;
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 4; k++) begin
            ce = (k < 2) ? 2'h2 : (k == 2) ? 2'h0 : 2'h1;
            m = (k < 2) ? 16'h00FF : (k == 2) ? 16'hFFFF : 16'hFF00;
            e = (k == 0) ? {8'h00, RDW[7:0]} :
                (k == 1) ? {8'h00, RDW[15:8]} : RDW & m;
            u_chb_host.xfer(s[1:0], 1'b0, ce,
               {2'h0, k == 1 || (k > 1 && s == 1)}, 16'h0000, 40, rd, oe);
            chk("read data", e, rd & m);
            chk("read lanes", {14'h0, m[15], m[0]}, {14'h0, oe});
            chk("wait", 16'h1, {15'h0, u_chb_host.saw_wait});
            if (s == 0) begin
               chk("wide", 16'h1, {15'h0, u_chb_host.wide_seen});
            end
         end
      end
   endtask
   task automatic t_fifo();
      logic [15:0] e;
      logic [1:0] l;
      int n;
      wr_ready = 1'b0;
      u_chb_host.xfer(2'h0, 1'b1, 2'h2, 3'h0, 16'h5577, 40, rd, oe);
      u_chb_host.xfer(2'h1, 1'b1, 2'h1, 3'h1, 16'h8866, 40, rd, oe);
      for (int i = 2; i < 16; i++) begin
         u_chb_host.xfer(2'h0, 1'b1, 2'h0, 3'h0, 16'h1000 + 16'(i), 40, rd, oe);
      end
      // Sixteenth word fills the buffer, so this one must be held off
      u_chb_host.xfer(2'h0, 1'b1, 2'h0, 3'h0, 16'hDEAD, 8, rd, oe);
      chk("full", 16'h1, {15'h0, u_chb_host.saw_wait});
      n = 0;
      for (int c = 0; c < 40; c++) begin
         @(negedge clk);
         wr_ready = 1'b1;
         if (wr_valid === 1'b1) begin
            l = (n == 0) ? 2'h1 : (n == 1) ? 2'h2 : 2'h3;
            e = (n == 0) ? 16'h0077 : (n == 1) ? 16'h8800 : 16'h1000 + 16'(n);
            chk("wr data", e, wr_data & {{8{l[1]}}, {8{l[0]}}});
            chk("wr lanes", {14'h0, l}, {14'h0, wr_lanes});
            chk("wr index", {15'h0, n == 1}, {13'h0, wr_index});
            chk("wr ctrl", 16'h0, {15'h0, wr_is_ctrl});
            n++;
         end
      end
      chk("wr count", 16'h0010, 16'(n));
   endtask
   task automatic t_mode();
      interface_select_input_n = 1'b0;
      reset = 1'b1;
      repeat (20) @(negedge clk);
      reset = 1'b0;
      repeat (8) @(negedge clk);
      chk("disk at start", 16'h1, {15'h0, disk_mode});
      u_chb_host.xfer(2'h2, 1'b0, 2'h3, 3'h3, 16'h0000, 40, rd, oe);
      chk("task byte", {8'h00, RDW[7:0]}, rd & 16'h00FF);
      chk("task lanes", 16'h1, {14'h0, oe});
      chk("reg index", 16'h3, {13'h0, reg_index});
      chk("reg ctrl", 16'h0, {15'h0, reg_is_ctrl});
      u_chb_host.xfer(2'h2, 1'b0, 2'h3, 3'h0, 16'h0000, 40, rd, oe);
      chk("data word", RDW, rd);
      chk("data lanes", 16'h3, {14'h0, oe});
      interface_select_input_n = 1'b1;
      repeat (10) @(negedge clk);
      chk("select high", 16'h0, {15'h0, disk_mode});
      interface_select_input_n = 1'b0;
      repeat (20) @(negedge clk);
      chk("short low", 16'h0, {15'h0, disk_mode});
      repeat (70) @(negedge clk);
      chk("long low", 16'h1, {15'h0, disk_mode});
      interface_select_input_n = 1'b1;
      repeat (10) @(negedge clk);
   endtask
   initial begin
      reset = 1'b1;
      interface_select_input_n = 1'b1;
      speed_cfg = 2'h0;
      wr_ready = 1'b1;
      rd_word = RDW;
      repeat (20) @(negedge clk);
      reset = 1'b0;
      repeat (6) @(negedge clk);
      t_speed();
      t_read();
      t_fifo();
      t_mode();
      finish_test();
   end
endmodule
